// ==== logic/rac_ctrl.sv ====
// Alarm and non-volatile control register bank of a real-time clock.
// Assumes a serial front end giving one-cycle byte strobes, a calendar
// that updates with a one-second pulse, and external persistent storage
// that mirrors the image output and restores it through the reset load.
`timescale 1ns/100ps

module rac_ctrl (
	// Clock, reset, enable
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	input wire logic clk_en_in,
	// Persistent image restore and mirror
	input wire rac_pkg::rac_nv_t nv_image_in,
	output rac_pkg::rac_nv_t nv_image_out,
	// Register byte access
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic write_enable_latch_in,
	output logic [7:0] reg_rdata_out,
	// Calendar and alarm status
	input wire rac_pkg::rac_cal_t cal_in,
	input wire logic sec_tick_in,
	input wire logic status_read_in,
	output logic alarm_a_flag_out,
	output logic alarm_b_flag_out,
	// Array write gate
	input wire logic arr_wr_req_in,
	input wire logic [8:0] arr_addr_in,
	output logic arr_wr_ok_out,
	output logic arr_wr_drop_out,
	// Oscillator trim
	output logic [6:0] cap_half_pf_out,
	output logic count_add_out,
	output logic count_drop_out,
	// Power control
	input wire logic backup_mode_in,
	output logic bus_enable_out,
	output logic switchover_mode_out,
	output logic [2:0] reset_threshold_code_out,
	output logic [12:0] reset_threshold_mv_out
);
	import rac_pkg::*;

	// ------------------------------------------------------------
	// State and helpers
	// ------------------------------------------------------------
	rac_state_t st_ff;
	rac_state_t nxt_st;
	logic [1:0] match;

	function automatic logic prot_hit(input logic [2:0] sel, input logic [8:0] a);
		logic hit;
		hit = 1'b0;
		unique case (sel)
			3'h0: hit = 1'b0;
			3'h1: hit = a >= RAC_ARR_Q3;
			3'h2: hit = a >= RAC_ARR_HALF;
			3'h3: hit = a <= RAC_ARR_LAST;
			3'h4: hit = a <= RAC_ARR_P4_END;
			3'h5: hit = a <= RAC_ARR_P8_END;
			3'h6: hit = a <= RAC_ARR_P16_END;
			3'h7: hit = a <= RAC_ARR_LAST;
		endcase
		return hit;
	endfunction

	// ------------------------------------------------------------
	// Alarm comparators
	// ------------------------------------------------------------
	genvar s;
	generate
		for (s = 0; s < 2; s++) begin : g_alarm
			rac_alarm_cmp u_cmp (
				.alm_in(st_ff.nv.alm[s]),
				.cal_in(cal_in.b),
				.match_out(match[s])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic set_sel;
		logic [2:0] slot;
		logic [4:0] ppm;
		logic [20:0] sum;
		logic [7:0] rd;
		set_sel = reg_addr_in[3];
		slot = (reg_addr_in[2:0] == RAC_ALM_DOW_POS) ? RAC_ALM_YEAR_POS : reg_addr_in[2:0];
		ppm = 5'h00;
		sum = 21'h000000;
		rd = 8'h00;
		nxt_st = st_ff;
		nxt_st.arr_ok = 1'b0;
		nxt_st.arr_drop = 1'b0;
		nxt_st.cnt_add = 1'b0;
		nxt_st.cnt_drop = 1'b0;

		// Register writes need the latch; year slots hold nothing
		if (reg_wr_in && write_enable_latch_in) begin
			if (reg_addr_in[7:4] == RAC_ALM_A_BASE[7:4] || reg_addr_in[7:4] == RAC_ALM_B_BASE[7:4]) begin
				if (reg_addr_in[2:0] != RAC_ALM_YEAR_POS && reg_addr_in[2:0] != RAC_ALM_CENT_POS) begin
					nxt_st.nv.alm[set_sel][slot] = reg_wdata_in & RAC_ALM_MASK[slot];
				end
			end else if (reg_addr_in == RAC_OFS_PROTECT) begin
				nxt_st.nv.protect = reg_wdata_in & RAC_PROTECT_MASK;
			end else if (reg_addr_in == RAC_OFS_ATRIM) begin
				nxt_st.nv.atrim = reg_wdata_in & RAC_ATRIM_MASK;
			end else if (reg_addr_in == RAC_OFS_DTRIM) begin
				nxt_st.nv.dtrim = reg_wdata_in & RAC_DTRIM_MASK;
			end else if (reg_addr_in == RAC_OFS_PWR) begin
				// Threshold field is open to any accepted write
				nxt_st.nv.power_control = reg_wdata_in & RAC_PWR_MASK;
			end
		end

		// Register reads
		if (reg_addr_in[7:4] == RAC_ALM_A_BASE[7:4] || reg_addr_in[7:4] == RAC_ALM_B_BASE[7:4]) begin
			if (reg_addr_in[2:0] == RAC_ALM_YEAR_POS) begin
				rd = cal_in.yr;
			end else if (reg_addr_in[2:0] != RAC_ALM_CENT_POS) begin
				rd = st_ff.nv.alm[set_sel][slot];
			end
		end else if (reg_addr_in == RAC_OFS_PROTECT) begin
			rd = st_ff.nv.protect;
		end else if (reg_addr_in == RAC_OFS_ATRIM) begin
			rd = st_ff.nv.atrim;
		end else if (reg_addr_in == RAC_OFS_DTRIM) begin
			rd = st_ff.nv.dtrim;
		end else if (reg_addr_in == RAC_OFS_PWR) begin
			rd = st_ff.nv.power_control;
		end
		if (reg_rd_in) begin
			nxt_st.rdata = rd;
		end

		// Alarm flags: a match in the clearing cycle still sets
		nxt_st.flags = (st_ff.flags & ~{2{status_read_in}}) | (sec_tick_in ? match : 2'b00);

		// Array write gate
		if (arr_wr_req_in) begin
			nxt_st.arr_drop = prot_hit(st_ff.nv.protect[RAC_PROT_SEL_LSB +: 3], arr_addr_in);
			nxt_st.arr_ok = !nxt_st.arr_drop;
		end

		// Digital trim: fractional count accumulator per second
		if (st_ff.nv.dtrim[RAC_RATE_10_BIT]) begin
			ppm = ppm + RAC_PPM_STEP_10;
		end
		if (st_ff.nv.dtrim[RAC_RATE_20_BIT]) begin
			ppm = ppm + RAC_PPM_STEP_20;
		end
		if (sec_tick_in) begin
			sum = {1'b0, st_ff.acc} + 21'(ppm) * RAC_OSC_HZ;
			if (sum >= RAC_PPM_DEN) begin
				sum = sum - RAC_PPM_DEN;
				nxt_st.cnt_add = !st_ff.nv.dtrim[RAC_RATE_SIGN_BIT];
				nxt_st.cnt_drop = st_ff.nv.dtrim[RAC_RATE_SIGN_BIT];
			end
			nxt_st.acc = sum[19:0];
		end

		// Analog trim in half picofarads
		nxt_st.cap = 7'({~st_ff.nv.atrim[RAC_CAP_MSB_BIT], st_ff.nv.atrim[4:0]}) + RAC_CAP_FIXED_HALF_PF;

		// Power control
		nxt_st.bus_en = !(backup_mode_in && st_ff.nv.power_control[RAC_BUS_INHIBIT_BIT]);
		nxt_st.switchover = st_ff.nv.power_control[RAC_SWITCHOVER_BIT];
		if (st_ff.nv.power_control[2:0] > RAC_VRST_LAST_CODE) begin
			nxt_st.lvl = RAC_VRST_DEFAULT_CODE;
		end else begin
			nxt_st.lvl = st_ff.nv.power_control[2:0];
		end
		nxt_st.mv = RAC_VRST_MV[nxt_st.lvl];
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			st_ff <= '0;
			// Persistent contents come back from storage
			st_ff.nv <= nv_image_in;
			st_ff.bus_en <= 1'b1;
			st_ff.cap <= RAC_CAP_FIXED_HALF_PF;
			st_ff.mv <= RAC_VRST_MV[RAC_VRST_DEFAULT_CODE];
		end else if (clk_en_in) begin
			st_ff <= nxt_st;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign nv_image_out = st_ff.nv;
	assign reg_rdata_out = st_ff.rdata;
	assign alarm_a_flag_out = st_ff.flags[0];
	assign alarm_b_flag_out = st_ff.flags[1];
	assign arr_wr_ok_out = st_ff.arr_ok;
	assign arr_wr_drop_out = st_ff.arr_drop;
	assign cap_half_pf_out = st_ff.cap;
	assign count_add_out = st_ff.cnt_add;
	assign count_drop_out = st_ff.cnt_drop;
	assign bus_enable_out = st_ff.bus_en;
	assign switchover_mode_out = st_ff.switchover;
	assign reset_threshold_code_out = st_ff.lvl;
	assign reset_threshold_mv_out = st_ff.mv;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_wel_blocks_write: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		clk_en_in && reg_wr_in && !write_enable_latch_in |=> $stable(nv_image_out))
		else $error("register write taken with latch clear");

	a_prot_full_drop: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		clk_en_in && arr_wr_req_in && nv_image_out.protect[7:5] == 3'h3 |=> arr_wr_drop_out && !arr_wr_ok_out)
		else $error("write into fully protected array not dropped");

	a_prot_low_edge: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		clk_en_in && arr_wr_req_in && nv_image_out.protect[7:5] == 3'h4 && arr_addr_in == 9'h040
		|=> arr_wr_ok_out && !arr_wr_drop_out)
		else $error("first unprotected byte after four pages refused");

	a_alarm_sets_flag: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		clk_en_in && sec_tick_in && match[0] |=> alarm_a_flag_out)
		else $error("matching alarm did not set its flag");

	a_empty_no_match: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		nv_image_out.alm[1][0][7] == 1'b0 && nv_image_out.alm[1][1][7] == 1'b0 && nv_image_out.alm[1][2][7] == 1'b0
		&& nv_image_out.alm[1][3][7] == 1'b0 && nv_image_out.alm[1][4][7] == 1'b0
		&& nv_image_out.alm[1][5][7] == 1'b0 |-> !match[1])
		else $error("alarm with no enabled byte matched");

	a_bus_inhibit: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		clk_en_in && backup_mode_in |=> bus_enable_out == !$past(nv_image_out.power_control[7]))
		else $error("bus enable wrong in backup mode");

	a_vrst_undoc: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		clk_en_in && nv_image_out.power_control[2:0] > 3'h4 |=> reset_threshold_mv_out == 13'h1220)
		else $error("undocumented threshold code not mapped to default");

	a_trim_zero_idle: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		clk_en_in && nv_image_out.dtrim[1:0] == 2'b00 |=> !count_add_out && !count_drop_out)
		else $error("trim pulse with zero magnitude");

	a_cap_formula: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		clk_en_in && $stable(nv_image_out.atrim) && nv_image_out.atrim[5:0] == 6'h20 |=> cap_half_pf_out == 7'h12)
		else $error("load capacitor wrong for top bit only");

	a_alarm_b_flag: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		clk_en_in && sec_tick_in && match[1] |=> alarm_b_flag_out)
		else $error("matching second alarm did not set its flag");

	a_flag_clear: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		clk_en_in && status_read_in && !sec_tick_in |=> !alarm_a_flag_out && !alarm_b_flag_out)
		else $error("alarm flags not cleared by status read");

	a_flag_needs_tick: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		clk_en_in && !sec_tick_in && !alarm_a_flag_out |=> !alarm_a_flag_out)
		else $error("alarm flag set without a second update");

	a_prot_none_pass: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		clk_en_in && arr_wr_req_in && nv_image_out.protect[7:5] == 3'h0 |=> arr_wr_ok_out && !arr_wr_drop_out)
		else $error("array write refused with nothing protected");

	a_prot_upper_quarter: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		clk_en_in && arr_wr_req_in && nv_image_out.protect[7:5] == 3'h1
		|=> arr_wr_drop_out == ($past(arr_addr_in) >= 9'h180))
		else $error("upper quarter protection wrong");

	a_write_lands: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		clk_en_in && reg_wr_in && write_enable_latch_in && reg_addr_in == RAC_OFS_ATRIM
		|=> nv_image_out.atrim == ($past(reg_wdata_in) & RAC_ATRIM_MASK))
		else $error("accepted trim write not stored");

	a_bus_normal: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		clk_en_in && nrst_in && !backup_mode_in |=> bus_enable_out)
		else $error("bus disabled outside backup mode");

	a_switchover_follow: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		clk_en_in && nrst_in |=> switchover_mode_out == $past(nv_image_out.power_control[6]))
		else $error("switchover mode does not follow its bit");

	a_trim_one_way: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		!(count_add_out && count_drop_out))
		else $error("count added and removed at once");

	a_trim_sign: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		clk_en_in && nv_image_out.dtrim[2] |=> !count_add_out)
		else $error("count added with negative sign");

	a_code_range: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		reset_threshold_code_out <= 3'h4)
		else $error("threshold code beyond last level");

endmodule // rac_ctrl

// ==== logic/rac_pkg.sv ====
// Constants, field layouts and carrier types of the alarm and
// non-volatile control register bank of a real-time clock.
// Assumes a serial front end that delivers decoded byte accesses.
//
// What this block does
// - Alarm byte mirrors calendar byte layout; bit 7 is its match enable.
// - Only enabled alarm bytes take part in the match.
// - No year alarm byte; calendar year never joins the match.
// - Alarm fires when at least one byte is enabled and every enabled byte equals its calendar byte.
// - All control bits and alarm bytes persist as non-volatile contents.
// - Array writes into the protected range are silently discarded.
// - Protect 000 none, 001 180h-1FFh, 010 100h-1FFh, 011 whole array.
// - Protect 100 000h-03Fh, 101 000h-07Fh, 110 000h-0FFh, 111 whole array.
// - Pin capacitor is 16*not b5 + 8,4,2,1,0.5 weights + 9 pF.
// - Middle bit gives 10 ppm, low bit 20 ppm; zero means none.
// - Bus inhibit bit set disables the serial bus during battery backup.
// - Switchover bit 0 standard, 1 legacy; legacy is the default.
// - Reset level codes 000..100 give 4.64, 4.38, 3.09, 2.92, 2.63 V.
// - Reset level field has no write protection; changes only when written.
// - With the write enable latch clear, register writes are ignored.
// - A matching enabled alarm sets its status flag.

package rac_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] RAC_ALM_A_BASE = 8'h00;
	localparam logic [7:0] RAC_ALM_B_BASE = 8'h08;
	localparam logic [7:0] RAC_OFS_PROTECT = 8'h10;
	localparam logic [7:0] RAC_OFS_ATRIM = 8'h12;
	localparam logic [7:0] RAC_OFS_DTRIM = 8'h13;
	localparam logic [7:0] RAC_OFS_PWR = 8'h14;
	// Position of year and century bytes inside an alarm set
	localparam logic [2:0] RAC_ALM_YEAR_POS = 3'h5;
	localparam logic [2:0] RAC_ALM_CENT_POS = 3'h7;
	localparam logic [2:0] RAC_ALM_DOW_POS = 3'h6;
	localparam int RAC_ALM_SLOTS = 6;

	// ------------------------------------------------------------
	// Field layouts (writable bits)
	// ------------------------------------------------------------
	// Slots: 0 sec, 1 min, 2 hour, 3 date, 4 month, 5 weekday
	localparam logic [5:0][7:0] RAC_ALM_MASK = {8'h87, 8'h9F, 8'hBF, 8'hBF, 8'hFF, 8'hFF};
	localparam logic [7:0] RAC_ALM_VAL_MASK = 8'h7F;
	localparam int RAC_ALM_EN_BIT = 7;
	localparam logic [7:0] RAC_PROTECT_MASK = 8'hF8;
	localparam logic [7:0] RAC_ATRIM_MASK = 8'h3F;
	localparam logic [7:0] RAC_DTRIM_MASK = 8'h07;
	localparam logic [7:0] RAC_PWR_MASK = 8'hC7;
	localparam int RAC_PROT_SEL_LSB = 5;
	localparam int RAC_BUS_INHIBIT_BIT = 7;
	localparam int RAC_SWITCHOVER_BIT = 6;
	localparam int RAC_RATE_SIGN_BIT = 2;
	localparam int RAC_RATE_10_BIT = 1;
	localparam int RAC_RATE_20_BIT = 0;
	localparam int RAC_CAP_MSB_BIT = 5;

	// ------------------------------------------------------------
	// Array protect ranges
	// ------------------------------------------------------------
	localparam logic [8:0] RAC_ARR_LAST = 9'h1FF;
	localparam logic [8:0] RAC_ARR_Q3 = 9'h180;
	localparam logic [8:0] RAC_ARR_HALF = 9'h100;
	localparam logic [8:0] RAC_ARR_P4_END = 9'h03F;
	localparam logic [8:0] RAC_ARR_P8_END = 9'h07F;
	localparam logic [8:0] RAC_ARR_P16_END = 9'h0FF;

	// ------------------------------------------------------------
	// Trim and threshold constants
	// ------------------------------------------------------------
	// Load capacitor in half picofarads: fixed 9 pF part
	localparam logic [6:0] RAC_CAP_FIXED_HALF_PF = 7'h12;
	localparam logic [20:0] RAC_OSC_HZ = 21'h008000;
	localparam logic [20:0] RAC_PPM_DEN = 21'h0F4240;
	localparam logic [4:0] RAC_PPM_STEP_10 = 5'h0A;
	localparam logic [4:0] RAC_PPM_STEP_20 = 5'h14;
	localparam logic [2:0] RAC_VRST_LAST_CODE = 3'h4;
	localparam logic [2:0] RAC_VRST_DEFAULT_CODE = 3'h0;
	// Thresholds in millivolts, code 0 in the low slot
	localparam logic [4:0][12:0] RAC_VRST_MV = {13'h0A46, 13'h0B68, 13'h0C12, 13'h111C, 13'h1220};

	// ------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] yr;
		logic [5:0][7:0] b;
	} rac_cal_t;

	typedef struct packed {
		logic [1:0][5:0][7:0] alm;
		logic [7:0] protect;
		logic [7:0] atrim;
		logic [7:0] dtrim;
		logic [7:0] power_control;
	} rac_nv_t;

	typedef struct packed {
		rac_nv_t nv;
		logic [1:0] flags;
		logic [7:0] rdata;
		logic bus_en;
		logic switchover;
		logic [6:0] cap;
		logic [2:0] lvl;
		logic [12:0] mv;
		logic arr_ok;
		logic arr_drop;
		logic cnt_add;
		logic cnt_drop;
		logic [19:0] acc;
	} rac_state_t;

endpackage

// ==== logic/rac_alarm_cmp.sv ====
// Compare one alarm set against the running calendar.
// Assumes calendar bytes arrive in the alarm slot order.
`timescale 1ns/100ps

module rac_alarm_cmp (
	// Alarm set and calendar
	input wire logic [5:0][7:0] alm_in,
	input wire logic [5:0][7:0] cal_in,
	// Result
	output logic match_out
);
	import rac_pkg::*;

	logic [5:0] en;
	logic [5:0] eq;

	genvar k;
	generate
		for (k = 0; k < RAC_ALM_SLOTS; k++) begin : g_slot
			// Enable bit sits on top, value in the calendar layout
			assign en[k] = alm_in[k][RAC_ALM_EN_BIT];
			assign eq[k] = ((alm_in[k] ^ cal_in[k]) & RAC_ALM_MASK[k] & RAC_ALM_VAL_MASK) == 8'h00;
		end
	endgenerate

	// Disabled bytes always agree; an empty set never fires
	assign match_out = (|en) && (&(~en | eq));

endmodule // rac_alarm_cmp

// ==== testbench/rac_host.sv ====
// Host model: issues single byte register reads and writes.
// Assumes one-cycle strobes sampled on the rising edge of the bench clock.
`timescale 1ns/100ps

module rac_host (
	// Clock
	input wire logic sys_clk_in,
	// Register byte access
	output logic reg_wr_out,
	output logic reg_rd_out,
	output logic [7:0] reg_addr_out,
	output logic [7:0] reg_wdata_out,
	input wire logic [7:0] reg_rdata_in
);
	initial begin
		reg_wr_out <= 1'b0;
		reg_rd_out <= 1'b0;
		reg_addr_out <= 8'hA5;
		reg_wdata_out <= 8'h5A;
	end

	// Released lines show the inverse of the last value
	task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_in);
		reg_wr_out <= 1'b1;
		reg_addr_out <= a;
		reg_wdata_out <= d; // Reserved level codes go out only when a scenario asks
		@(posedge sys_clk_in);
		reg_wr_out <= 1'b0;
		reg_addr_out <= ~a;
		reg_wdata_out <= ~d;
	endtask

	task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk_in);
		reg_rd_out <= 1'b1;
		reg_addr_out <= a;
		@(posedge sys_clk_in);
		reg_rd_out <= 1'b0;
		reg_addr_out <= ~a;
		@(posedge sys_clk_in);
		#1;
		d = reg_rdata_in;
	endtask
endmodule // rac_host

// ==== testbench/rtc_alarm_and_nv_control_regs_bench.sv ====
// Self-checking bench of the alarm and non-volatile control bank.
// Assumes the host model drives the register port; the bench drives the rest.
`timescale 1ns/100ps

module rtc_alarm_and_nv_control_regs_bench;
	import rac_pkg::*;
	logic sys_clk_in, nrst_in, ce, write_enable_latch, tick, st_rd, arr_req, backup, reg_wr, reg_rd;
	logic [8:0] arr_addr;
	logic [7:0] addr, wdata, rdata, rd;
	rac_nv_t image, nv_out;
	rac_cal_t cal;
	logic fa, fb, ok, drop, add, dropc, bus_en, swm;
	logic [6:0] cap;
	logic [2:0] code;
	logic [12:0] mv;
	int err_total, comparisons, adds, drops;

	rac_host host (.sys_clk_in(sys_clk_in), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd),
		.reg_addr_out(addr), .reg_wdata_out(wdata), .reg_rdata_in(rdata));

	rac_ctrl DUT (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .clk_en_in(ce),
		.nv_image_in(image), .nv_image_out(nv_out), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .write_enable_latch_in(write_enable_latch), .reg_rdata_out(rdata),
		.cal_in(cal), .sec_tick_in(tick), .status_read_in(st_rd), .alarm_a_flag_out(fa),
		.alarm_b_flag_out(fb), .arr_wr_req_in(arr_req), .arr_addr_in(arr_addr), .arr_wr_ok_out(ok),
		.arr_wr_drop_out(drop), .cap_half_pf_out(cap), .count_add_out(add), .count_drop_out(dropc),
		.backup_mode_in(backup), .bus_enable_out(bus_en), .switchover_mode_out(swm),
		.reset_threshold_code_out(code), .reset_threshold_mv_out(mv));

	initial begin
		sys_clk_in = 1'b0;
		forever #50 sys_clk_in = ~sys_clk_in;
	end

	// Trim pulse counters
	always @(posedge sys_clk_in) begin
		if (add === 1'b1) adds++;
		if (dropc === 1'b1) drops++;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic conclude;
		$display("comparisons %0d errors %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic do_reset;
		@(posedge sys_clk_in);
		nrst_in <= 1'b0;
		repeat (6) @(posedge sys_clk_in);
		nrst_in <= 1'b1;
		repeat (3) @(posedge sys_clk_in);
		#1;
	endtask

	task automatic pulse_tick;
		@(posedge sys_clk_in);
		tick <= 1'b1;
		@(posedge sys_clk_in);
		tick <= 1'b0;
		#1;
	endtask

	task automatic arr_try(input logic [8:0] a, input logic pr);
		@(posedge sys_clk_in);
		arr_req <= 1'b1;
		arr_addr <= a;
		@(posedge sys_clk_in);
		arr_req <= 1'b0;
		arr_addr <= ~a;
		#1;
		chk({ok, drop}, {~pr, pr});
	endtask

	function automatic logic prot(input logic [2:0] c, input logic [8:0] a);
		case (c)
			3'h1: return a >= 9'h180;
			3'h2: return a >= 9'h100;
			3'h3, 3'h7: return 1'b1;
			3'h4: return a <= 9'h03F;
			3'h5: return a <= 9'h07F;
			3'h6: return a <= 9'h0FF;
			default: return 1'b0;
		endcase
	endfunction

	task automatic test_defaults;
		chk({15'h0, nv_out === image}, 16'h1);
		chk(swm, 1'b1);
		chk(code, 3'h0);
		chk(mv, 13'h1220);
		chk(cap, 7'h51);
		chk(bus_en, 1'b1);
	endtask

	task automatic test_regs;
		logic [7:0] v[4] = '{8'h00, 8'h20, 8'h1F, 8'hFF};
		@(posedge sys_clk_in);
		write_enable_latch <= 1'b0;
		host.write_byte(RAC_OFS_ATRIM, 8'h00);
		host.read_byte(RAC_OFS_ATRIM, rd);
		chk(rd, 8'h1F);
		@(posedge sys_clk_in);
		write_enable_latch <= 1'b1;
		foreach (v[i]) begin
			host.write_byte(RAC_OFS_ATRIM, v[i]);
			host.read_byte(RAC_OFS_ATRIM, rd);
			chk(rd, v[i] & 8'h3F);
			chk(cap, {~v[i][5], 5'h0} + v[i][4:0] + 7'h12);
		end
		host.read_byte(8'h20, rd);
		chk(rd, 8'h00);
		// Clock enable low freezes the bank: the write must not land
		@(posedge sys_clk_in);
		ce <= 1'b0;
		host.write_byte(RAC_OFS_ATRIM, 8'h00);
		@(posedge sys_clk_in);
		ce <= 1'b1;
		#1;
		chk(nv_out.atrim, 8'h3F);
	endtask

	task automatic test_alarm;
		host.write_byte(8'h00, 8'hB0);
		host.write_byte(8'h01, 8'h45);
		host.write_byte(8'h06, 8'h83);
		host.write_byte(8'h08, 8'h30);
		@(posedge sys_clk_in);
		cal <= {8'h99, 8'h03, 8'h12, 8'h07, 8'h11, 8'h12, 8'h30};
		pulse_tick;
		chk(fa, 1'b1);
		chk(fb, 1'b0);
		host.read_byte(8'h05, rd);
		chk(rd, 8'h99);
		@(posedge sys_clk_in);
		st_rd <= 1'b1;
		cal.b[5] <= 8'h04;
		@(posedge sys_clk_in);
		st_rd <= 1'b0;
		#1;
		chk(fa, 1'b0);
		pulse_tick;
		chk(fa, 1'b0);
		@(posedge sys_clk_in);
		cal.b[5] <= 8'h03;
		cal.yr <= 8'h00;
		pulse_tick;
		chk(fa, 1'b1);
		host.write_byte(8'h08, 8'hB0);
		pulse_tick;
		chk(fb, 1'b1);
	endtask

	task automatic test_array;
		logic [8:0] pt[10] = '{9'h000, 9'h03F, 9'h040, 9'h07F, 9'h080, 9'h0FF, 9'h100, 9'h17F, 9'h180, 9'h1FF};
		for (int c = 0; c < 8; c++) begin
			host.write_byte(RAC_OFS_PROTECT, {c[2:0], 5'h1F});
			host.read_byte(RAC_OFS_PROTECT, rd);
			chk(rd, {c[2:0], 5'h18});
			foreach (pt[i]) arr_try(pt[i], prot(c[2:0], pt[i]));
		end
	endtask

	task automatic test_power;
		logic [12:0] lv[8] = '{13'h1220, 13'h111C, 13'h0C12, 13'h0B68, 13'h0A46, 13'h1220, 13'h1220, 13'h1220};
		for (int c = 0; c < 8; c++) begin
			host.write_byte(RAC_OFS_PWR, {5'h10, c[2:0]});
			repeat (2) @(posedge sys_clk_in);
			#1;
			chk(code, c < 5 ? c[2:0] : 3'h0);
			chk(mv, lv[c]);
			chk(swm, 1'b0);
		end
		@(posedge sys_clk_in);
		backup <= 1'b1;
		repeat (2) @(posedge sys_clk_in);
		#1;
		chk(bus_en, 1'b0);
		host.write_byte(RAC_OFS_PWR, 8'h40);
		repeat (2) @(posedge sys_clk_in);
		#1;
		chk(bus_en, 1'b1);
		chk(swm, 1'b1);
		@(posedge sys_clk_in);
		backup <= 1'b0;
	endtask

	task automatic test_rate;
		logic [7:0] dt[4] = '{8'h03, 8'h06, 8'h04, 8'h01};
		int ea[4] = '{9, 0, 0, 6};
		int ed[4] = '{0, 3, 0, 0};
		foreach (dt[i]) begin
			@(posedge sys_clk_in);
			image.dtrim <= dt[i];
			do_reset;
			adds = 0;
			drops = 0;
			repeat (10) pulse_tick;
			repeat (3) @(posedge sys_clk_in);
			#1;
			chk(adds, ea[i]);
			chk(drops, ed[i]);
		end
	endtask

	initial begin
		nrst_in <= 1'b0;
		ce <= 1'b1;
		write_enable_latch <= 1'b1;
		tick <= 1'b0;
		st_rd <= 1'b0;
		arr_req <= 1'b0;
		arr_addr <= 9'h000;
		backup <= 1'b0;
		// Image order: alarms, protect, analog trim, digital trim, power
		image <= {96'h0, 8'h00, 8'h1F, 8'h00, 8'h40};
		cal <= '0;
		err_total = 0;
		comparisons = 0;
		do_reset;
		test_defaults;
		test_regs;
		test_alarm;
		test_array;
		test_power;
		test_rate;
		conclude;
	end

	// Watchdog: the whole run needs a few hundred cycles
	initial begin
		#3_000_000;
		err_total++;
		conclude;
	end
endmodule // rtc_alarm_and_nv_control_regs_bench
